// [hw/sdm_source_driver.v]
`timescale 1ns/1ps
`include "sdm_defines.vh"
`default_nettype none
module sdm_source_driver (
  input wire clk,
  input wire nrst,
  input wire [35:0] dot_gray_inputs,
  input wire dot_valid,
  output reg dot_ready,
  input wire polarity_select,
  input wire line_latch_strobe,
  input wire shift_right,
  input wire cascade_pulse_right_in,
  output reg cascade_pulse_right_out,
  output reg cascade_pulse_right_oe_n,
  input wire cascade_pulse_left_in,
  output reg cascade_pulse_left_out,
  output reg cascade_pulse_left_oe_n,
  output reg [2303:0] column_outputs,
  output reg [383:0] column_ref_upper
);

  // Reference group for one column: 1 selects references 5 to 9
  function ref_upper;
    input odd_col;
    input polarity;
    begin
      // Odd columns follow the select, even columns take the other group
      ref_upper = odd_col ? polarity : ~polarity;
    end
  endfunction

  // Next fill index, rising for right shift, falling for left
  // Index wraps at either end; the word count, not the index, ends a line
  function [5:0] step_idx;
    input [5:0] idx;
    input right;
    begin
      step_idx = right ? idx + 6'h01 : idx - 6'h01;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two stages for every asynchronous input
  reg [41:0] sync1_r;
  reg [41:0] sync2_r;
  reg strobe_d_r;
  reg start_d_r;
  wire [41:0] pins;
  wire dir_s;
  wire polarity_s;
  wire strobe_s;
  wire valid_s;
  wire [35:0] data_s;
  wire start_s;
  wire strobe_rise;
  wire strobe_fall;
  wire start_rise;
  assign pins = {shift_right, polarity_select, line_latch_strobe,
    cascade_pulse_right_in, cascade_pulse_left_in, dot_valid,
    dot_gray_inputs};

  // Word and valid share one stage pair, so each word arrives with its
  // own valid; the source must hold the word steady around that cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 42'h000_0000_0000;
      sync2_r <= 42'h000_0000_0000;
      strobe_d_r <= 1'b0;
      start_d_r <= 1'b0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      strobe_d_r <= strobe_s;
      start_d_r <= start_s;
    end
  end

  // Synchronised views of the pins
  assign dir_s = sync2_r[`SDM_SYNC_DIR_BIT];
  assign polarity_s = sync2_r[`SDM_SYNC_POLARITY_BIT];
  assign strobe_s = sync2_r[`SDM_SYNC_STROBE_BIT];
  assign valid_s = sync2_r[`SDM_SYNC_VALID_BIT];
  assign data_s = sync2_r[`SDM_WORD_W-1:0];
  // Start pulse enters on the pin facing the shift origin
  assign start_s = dir_s ? sync2_r[`SDM_SYNC_START_R_BIT] :
    sync2_r[`SDM_SYNC_START_L_BIT];
  // Edge detectors reset low to match the idle pin level
  assign strobe_rise = strobe_s & ~strobe_d_r;
  assign strobe_fall = ~strobe_s & strobe_d_r;
  assign start_rise = start_s & ~start_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer between the input word and the data register
  reg [35:0] buf0_r;
  reg [35:0] buf1_r;
  reg [1:0] cnt_r;
  reg [1:0] cnt_nxt;
  reg armed_r;
  wire push;
  wire pop;
  // Drain stalls in the latch cycle so the latch sees a stable register
  // Words outside an armed line are dropped, never stored
  assign push = valid_s & armed_r & (cnt_r != 2'h2);
  assign pop = (cnt_r != 2'h0) & ~strobe_rise;

  always @* begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buf0_r <= 36'h0_0000_0000;
      buf1_r <= 36'h0_0000_0000;
      cnt_r <= 2'h0;
      dot_ready <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      dot_ready <= armed_r & (cnt_nxt != 2'h2);
      if (pop) begin
        buf0_r <= (cnt_r == 2'h2) ? buf1_r : data_s;
      end else if (push && cnt_r == 2'h0) begin
        buf0_r <= data_s;
      end
      if (push && ((cnt_r == 2'h1 && !pop) || (cnt_r == 2'h2 && pop))) begin
        buf1_r <= data_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture sequencer and 64-stage data register
  reg [35:0] data_mem [0:63];
  reg [5:0] idx_r;
  reg [5:0] words_r;
  reg run_dir_r;
  wire last_word;
  // Line is complete when the 64th word leaves the buffer
  assign last_word = pop & (words_r == `SDM_IDX_LAST);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed_r <= 1'b0;
      idx_r <= 6'h00;
      words_r <= 6'h00;
      run_dir_r <= 1'b1;
    end else begin
      if (start_rise && !armed_r) begin
        armed_r <= 1'b1;
        run_dir_r <= dir_s;
        // Left shift fills from the top group down; field order stays
        idx_r <= dir_s ? 6'h00 : `SDM_IDX_LAST;
        words_r <= 6'h00;
      end else if (pop) begin
        idx_r <= step_idx(idx_r, run_dir_r);
        words_r <= words_r + 6'h01;
        if (last_word) begin
          armed_r <= 1'b0;
        end
      end
    end
  end

  // Word storage has no reset: every stage is rewritten in each line that has a start pulse
  always @(posedge clk) begin
    if (pop) begin
      data_mem[idx_r] <= buf0_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cascade start pulse out, one cycle after the 64th word
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cascade_pulse_right_out <= 1'b0;
      cascade_pulse_left_out <= 1'b0;
      cascade_pulse_right_oe_n <= 1'b1;
      cascade_pulse_left_oe_n <= 1'b1;
    end else begin
      // Pins turn around with the synchronised direction
      cascade_pulse_right_oe_n <= dir_s;
      cascade_pulse_left_oe_n <= ~dir_s;
      cascade_pulse_right_out <= last_word & ~run_dir_r;
      cascade_pulse_left_out <= last_word & run_dir_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line latch on strobe rise, panel update on strobe fall
  reg [2303:0] latch_r;
  integer k;
  integer c;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_r <= {`SDM_LINE_W{1'b0}};
      column_outputs <= {`SDM_LINE_W{1'b0}};
      column_ref_upper <= {`SDM_COLS{1'b0}};
    end else begin
      if (strobe_rise) begin
        for (k = 0; k < `SDM_STAGES; k = k + 1) begin
          // Field 0 lands on the lowest column of its group
          latch_r[k*`SDM_WORD_W +: `SDM_WORD_W] <= data_mem[k];
        end
      end
      // Polarity is taken at the fall, so a late change still counts
      if (strobe_fall) begin
        column_outputs <= latch_r;
        for (c = 0; c < `SDM_COLS; c = c + 1) begin
          // Index c is column c+1, so even c is an odd column
          column_ref_upper[c] <= ref_upper(c % 2 == 0, polarity_s);
        end
      end
    end
  end

endmodule
`default_nettype wire

// [hw/sdm_defines.vh]
// Summary of operation
// - Each transfer carries six 6-bit gray dots as one 36-bit word.
// - Dot fields go to six adjacent columns in field order, either direction.
// - Polarity low: odd columns use lower references, even use upper.
// - Polarity high: groups swap, odd columns upper, even columns lower.
// - New column levels reach the panel on the line strobe falling edge.
`ifndef SDM_DEFINES_VH
`define SDM_DEFINES_VH
`define SDM_DOT_W 6
`define SDM_DOTS 6
`define SDM_WORD_W 36
`define SDM_STAGES 64
`define SDM_IDX_W 6
`define SDM_IDX_LAST 6'h3F
`define SDM_COLS 384
`define SDM_LINE_W 2304
`define SDM_SYNC_W 42
`define SDM_SYNC_DIR_BIT 41
`define SDM_SYNC_POLARITY_BIT 40
`define SDM_SYNC_STROBE_BIT 39
`define SDM_SYNC_START_R_BIT 38
`define SDM_SYNC_START_L_BIT 37
`define SDM_SYNC_VALID_BIT 36
`define SDM_LINE_PERIOD_US 20
`define SDM_CHAR_SHIFT_MHZ 40
`endif

// [verif/sdm_checker_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module sdm_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic polarity_select,
  input wire logic line_latch_strobe,
  input wire logic shift_right,
  input wire logic cascade_pulse_right_out,
  input wire logic cascade_pulse_right_oe_n,
  input wire logic cascade_pulse_left_out,
  input wire logic cascade_pulse_left_oe_n,
  input wire logic [2303:0] column_outputs,
  input wire logic [383:0] column_ref_upper
);
  // Strobe is held low long enough for the slack of six edges
  property p_pol_lo;
    @(posedge clk) disable iff (!nrst) $fell(line_latch_strobe) &&
      !polarity_select |-> ##6 column_ref_upper == {192{2'b10}};
  endproperty
  a_pol_lo: assert property (p_pol_lo) else $error("ref low");
  property p_pol_hi;
    @(posedge clk) disable iff (!nrst) $fell(line_latch_strobe) &&
      polarity_select |-> ##6 column_ref_upper == {192{2'b01}};
  endproperty
  a_pol_hi: assert property (p_pol_hi) else $error("ref high");
  property p_col_hold;
    @(posedge clk) disable iff (!nrst)
      !$stable(column_outputs) |-> !line_latch_strobe;
  endproperty
  a_col_hold: assert property (p_col_hold) else $error("col");
  property p_pulse;
    @(posedge clk) disable iff (!nrst)
      cascade_pulse_left_out |=> !cascade_pulse_left_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  property p_dir;
    @(posedge clk) disable iff (!nrst) cascade_pulse_left_out |->
      shift_right && !cascade_pulse_left_oe_n;
  endproperty
  a_dir: assert property (p_dir) else $error("dir");
  property p_oe;
    @(posedge clk) disable iff (!nrst)
      shift_right [*4] |-> cascade_pulse_right_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_pulse_r;
    @(posedge clk) disable iff (!nrst)
      cascade_pulse_right_out |=> !cascade_pulse_right_out;
  endproperty
  a_pulse_r: assert property (p_pulse_r) else $error("pulse right");
  property p_dir_r;
    @(posedge clk) disable iff (!nrst) cascade_pulse_right_out |->
      !shift_right && !cascade_pulse_right_oe_n;
  endproperty
  a_dir_r: assert property (p_dir_r) else $error("dir right");
  property p_oe_l;
    @(posedge clk) disable iff (!nrst) !shift_right [*4] |->
      cascade_pulse_left_oe_n && !cascade_pulse_right_oe_n;
  endproperty
  a_oe_l: assert property (p_oe_l) else $error("oe left");
endmodule
bind sdm_source_driver sdm_checker u_sdm_checker (
  .clk(clk),
  .nrst(nrst),
  .polarity_select(polarity_select),
  .line_latch_strobe(line_latch_strobe),
  .shift_right(shift_right),
  .cascade_pulse_right_out(cascade_pulse_right_out),
  .cascade_pulse_right_oe_n(cascade_pulse_right_oe_n),
  .cascade_pulse_left_out(cascade_pulse_left_out),
  .cascade_pulse_left_oe_n(cascade_pulse_left_oe_n),
  .column_outputs(column_outputs),
  .column_ref_upper(column_ref_upper)
);
`default_nettype wire

// [verif/sdm_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sdm_ctrl_model (
  input wire logic clk,
  input wire logic rdy,
  output logic [35:0] dot,
  output logic vld,
  output logic strobe,
  output logic polarity,
  output logic st_r,
  output logic st_l
);
  initial {dot, vld, strobe, polarity, st_r, st_l} = '0;
  // Start, 64 spaced words, one strobe per line; idle bus shows ~word
  // Field f of word i carries 6i+f plus an offset, cut to six bits
  task automatic line(input logic dir, input logic p, input logic go,
    input logic [5:0] ofs);
    int i;
    @(posedge clk);
    polarity <= p;
    st_r <= go & dir;
    st_l <= go & ~dir;
    @(posedge clk);
    {st_r, st_l} <= 2'b00;
    for (i = 0; i < 64; i++) begin
      while (go && !rdy) @(posedge clk);
      for (int f = 0; f < 6; f++) dot[6*f +: 6] <= 6'(6*i+f+ofs);
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      dot <= ~dot;
      repeat (3) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    strobe <= 1'b1;
    repeat (8) @(posedge clk);
    strobe <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [verif/sdm_source_driver_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sdm_source_driver_tb;
  logic clk = 0;
  logic nrst = 0;
  logic sr = 1;
  int errors = 0;
  int cmp_count = 0;
  int lo_cnt = 0;
  int ro_cnt = 0;
  wire [35:0] dot;
  wire vld, rdy, strobe, polarity, st_r, st_l, ro, roe, lo, loe;
  wire [2303:0] col;
  wire [383:0] up;
  sdm_ctrl_model u_sdm_ctrl_model (.clk(clk), .rdy(rdy), .dot(dot),
    .vld(vld), .strobe(strobe), .polarity(polarity), .st_r(st_r),
    .st_l(st_l));
  sdm_source_driver u_sdm_source_driver (.clk(clk), .nrst(nrst),
    .dot_gray_inputs(dot), .dot_valid(vld), .dot_ready(rdy),
    .polarity_select(polarity), .line_latch_strobe(strobe),
    .shift_right(sr),
    .cascade_pulse_right_in(roe ? st_r : ro),
    .cascade_pulse_right_out(ro), .cascade_pulse_right_oe_n(roe),
    .cascade_pulse_left_in(loe ? st_l : lo),
    .cascade_pulse_left_out(lo), .cascade_pulse_left_oe_n(loe),
    .column_outputs(col), .column_ref_upper(up));
  // Clock and watchdog; three lines need under 2000 cycles
  initial forever #2 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report;
  end
  // Count cascade out pulses for the per-line checks
  always @(posedge clk) begin
    if (lo === 1'b1)
      lo_cnt <= lo_cnt + 1;
    if (ro === 1'b1)
      ro_cnt <= ro_cnt + 1;
  end
  task automatic check(input logic dir, input logic p,
    input logic [5:0] ofs);
    logic [2303:0] ec;
    logic [383:0] er;
    for (int c = 0; c < 384; c++) begin
      ec[6*c +: 6] = 6'((dir ? c : 6*(63-c/6)+c%6) + ofs);
      // Index c is column c+1: even c is an odd column
      er[c] = p ^ c[0];
    end
    cmp_count++;
    if (col !== ec || up !== er) begin
      errors++;
      $display("CHECK FAILED %0t columns", $time);
    end
  endtask
  // Cascade out pulses seen so far on each pin
  task automatic check_pulse(input int r, input int l);
    cmp_count++;
    if (ro_cnt != r || lo_cnt != l) begin
      errors++;
      $display("CHECK FAILED %0t cascade pulses", $time);
    end
  endtask
  task automatic t_right_lo;
    u_sdm_ctrl_model.line(1'b1, 1'b0, 1'b1, 6'h00);
    check(1'b1, 1'b0, 6'h00);
    check_pulse(0, 1);
  endtask
  task automatic t_left_hi;
    sr <= 1'b0;
    repeat (6) @(posedge clk);
    u_sdm_ctrl_model.line(1'b0, 1'b1, 1'b1, 6'h0B);
    check(1'b0, 1'b1, 6'h0B);
    check_pulse(1, 1);
  endtask
  // Words with no start pulse must be dropped; fresh data would show
  task automatic t_idle_drop;
    u_sdm_ctrl_model.line(1'b0, 1'b0, 1'b0, 6'h15);
    check(1'b0, 1'b0, 6'h0B);
    check_pulse(1, 1);
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_right_lo;
    t_left_hi;
    t_idle_drop;
    final_report;
  end
endmodule
`default_nettype wire
